// ===== hiss_pkg.sv
// constants, types and helpers shared by the host port front end
// assumes the 8-bit host bus and the two strap pins of the display module
package hiss_pkg;

  // host data bus width
  localparam int DATA_W = 8;

  // strap codes as {proto_sel_hi, proto_sel_lo}
  localparam logic [1:0] STRAP_SER3 = 2'h1;
  localparam logic [1:0] STRAP_SER4 = 2'h0;
  localparam logic [1:0] STRAP_PAR68 = 2'h3;
  localparam logic [1:0] STRAP_PAR80 = 2'h2;

  // cycles the strap capture stays open after a reset ends
  localparam logic [2:0] STRAP_LD_CYCLES = 3'h5;

  // idle value driven on the host data bus
  localparam logic [7:0] BUS_IDLE = 8'h00;

  // host protocol in use
  typedef enum logic [1:0] {
    MODE_SER4 = 2'h0,
    MODE_SER3 = 2'h1,
    MODE_PAR80 = 2'h2,
    MODE_PAR68 = 2'h3
  } hiss_mode_t;

  // parallel transfer states, gray along idle-write and idle-read
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WRITE = 2'h1,
    ST_READ = 2'h2
  } hiss_state_t;

  // host control pins as one group
  typedef struct packed {
    logic cs_n;
    logic dc;
    logic rw_wr;
    logic e_rd;
  } hiss_ctl_t;

  // a received byte with its data or command tag
  typedef struct packed {
    logic is_data;
    logic [7:0] value;
  } hiss_byte_t;

  // control pins at rest: deselected, strobes idle
  localparam hiss_ctl_t CTL_RESET = '{cs_n: 1'h1, dc: 1'h0,
                                      rw_wr: 1'h1, e_rd: 1'h1};

  // strap code to protocol
  function automatic hiss_mode_t strap_to_mode(input logic [1:0] s);
    case (s)
      STRAP_SER3: strap_to_mode = MODE_SER3;
      STRAP_PAR68: strap_to_mode = MODE_PAR68;
      STRAP_PAR80: strap_to_mode = MODE_PAR80;
      default: strap_to_mode = MODE_SER4;
    endcase
  endfunction : strap_to_mode

endpackage : hiss_pkg

// ===== hiss_sync.sv
// three-stage synchroniser for pin inputs, one bit per lane
// assumes inputs are asynchronous to clk; a change is taken when the
// second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module hiss_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  // raw and filtered lanes
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  if (WIDTH < 1) begin : g_chk
    $error("hiss_sync needs WIDTH of at least one");
  end

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] q_ff;
  logic [WIDTH-1:0] nxt_q;

  // take a lane only where stages two and three agree
  assign nxt_q = (s2_ff & ~(s2_ff ^ s3_ff)) | (q_ff & (s2_ff ^ s3_ff));

  // stage chain
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
      q_ff <= INIT;
    end else if (en) begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;

endmodule : hiss_sync
`default_nettype wire

// ===== hiss_shift.sv
// serial receive shifter on the host's serial clock
// assumes msb first, sampled on rising clock edges; chip select high
// clears the bit count; word and toggle cross to the system clock
`timescale 1ns/1ps
`default_nettype none
module hiss_shift (
  // link clock and resets
  input wire logic ser_clk,
  input wire logic rst,
  input wire logic cs_n,
  // serial pins
  input wire logic serial_data_in,
  input wire logic dc_sel,
  // crossing to the system side
  output hiss_pkg::hiss_byte_t word,
  output logic tog
);

  logic [2:0] cnt_ff;
  logic [6:0] sh_ff;
  hiss_pkg::hiss_byte_t word_ff;
  logic tog_ff;

  // bit count and shift, held clear while deselected
  always_ff @(posedge ser_clk or posedge cs_n) begin
    if (cs_n) begin
      cnt_ff <= 3'h0;
      sh_ff <= 7'h00;
    end else begin
      cnt_ff <= cnt_ff + 3'h1;
      sh_ff <= {sh_ff[5:0], serial_data_in};
    end
  end

  // eighth bit: publish byte with its selector level, flip toggle
  always_ff @(posedge ser_clk or posedge rst) begin
    if (rst) begin
      word_ff <= '{is_data: 1'h0, value: 8'h00};
      tog_ff <= 1'h0;
    end else if (!cs_n && cnt_ff == 3'h7) begin
      word_ff <= '{is_data: dc_sel, value: {sh_ff, serial_data_in}};
      tog_ff <= ~tog_ff;
    end
  end

  assign word = word_ff;
  assign tog = tog_ff;

endmodule : hiss_shift
`default_nettype wire

// ===== hiss_host_port.sv
// host interface front end: protocol select, reset, chip select and
// data/command steering of each received byte
// assumes pins arrive asynchronously; serial clock is its own domain
`timescale 1ns/1ps
`default_nettype none
module hiss_host_port (
  // clocks, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic ser_clk,
  // straps and reset pin
  input wire logic proto_sel_lo,
  input wire logic proto_sel_hi,
  input wire logic reset_n_in,
  // host control pins
  input wire logic cs_n,
  input wire logic dc_sel,
  input wire logic rw_wr,
  input wire logic e_rd,
  // host data bus
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe_n,
  // core side
  input wire logic [7:0] rd_data,
  output logic core_init,
  output var hiss_pkg::hiss_mode_t mode,
  output logic cmd_valid,
  output logic data_valid,
  output logic [7:0] rx_byte,
  output logic rd_req,
  output logic rd_is_data,
  // aux pin a
  input wire logic aux_pin_a_dir,
  input wire logic aux_pin_a_val,
  input wire logic aux_pin_a_in,
  output logic aux_pin_a_out,
  output logic aux_pin_a_oe_n,
  output logic aux_pin_a_level,
  // aux pin b
  input wire logic aux_pin_b_dir,
  input wire logic aux_pin_b_val,
  input wire logic aux_pin_b_in,
  output logic aux_pin_b_out,
  output logic aux_pin_b_oe_n,
  output logic aux_pin_b_level
);

  localparam int SYNC_W = 18;
  localparam logic [SYNC_W-1:0] SYNC_INIT = {1'h1, 2'h0,
    hiss_pkg::CTL_RESET, hiss_pkg::BUS_IDLE, 2'h0, 1'h0};

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_q;
  logic rst_pin_n_q;
  logic [1:0] strap_q;
  hiss_pkg::hiss_ctl_t ctl_q;
  logic [7:0] bus_q;
  logic [1:0] aux_q;
  logic tog_q;
  logic link_tog;
  hiss_pkg::hiss_byte_t link_word;
  logic serial_data_in;
  logic core_rst;
  logic ready;
  logic wr_now;
  logic rd_now;
  logic is_serial;
  logic ser_new;
  logic init_ff;
  logic [2:0] ld_cnt_ff;
  hiss_pkg::hiss_mode_t mode_ff;
  hiss_pkg::hiss_state_t state_ff;
  hiss_pkg::hiss_state_t nxt_state;
  hiss_pkg::hiss_byte_t cap_ff;
  hiss_pkg::hiss_byte_t nxt_rx;
  logic nxt_go;
  logic tog_seen_ff;
  logic cmd_valid_ff;
  logic data_valid_ff;
  logic [7:0] rx_ff;
  logic rd_req_ff;
  logic rd_is_data_ff;
  logic [7:0] bus_out_ff;
  logic bus_oe_n_ff;
  logic aux_a_out_ff;
  logic aux_a_oe_n_ff;
  logic aux_b_out_ff;
  logic aux_b_oe_n_ff;

  // write strobe active for the current parallel mode
  function automatic logic wr_act(input hiss_pkg::hiss_mode_t m,
                                  input hiss_pkg::hiss_ctl_t c);
    case (m)
      hiss_pkg::MODE_PAR80: wr_act = !c.cs_n && !c.rw_wr;
      hiss_pkg::MODE_PAR68: wr_act = !c.cs_n && c.e_rd && !c.rw_wr;
      default: wr_act = 1'b0;
    endcase
  endfunction : wr_act

  // read strobe active for the current parallel mode
  function automatic logic rd_act(input hiss_pkg::hiss_mode_t m,
                                  input hiss_pkg::hiss_ctl_t c);
    case (m)
      hiss_pkg::MODE_PAR80: rd_act = !c.cs_n && !c.e_rd;
      hiss_pkg::MODE_PAR68: rd_act = !c.cs_n && c.e_rd && c.rw_wr;
      default: rd_act = 1'b0;
    endcase
  endfunction : rd_act

  assign sync_in = {reset_n_in, proto_sel_hi, proto_sel_lo, cs_n, dc_sel,
                    rw_wr, e_rd, host_data_bus_in, aux_pin_a_in,
                    aux_pin_b_in, link_tog};
  assign {rst_pin_n_q, strap_q, ctl_q, bus_q, aux_q, tog_q} = sync_q;

  hiss_sync #(.WIDTH(SYNC_W), .INIT(SYNC_INIT)) u_sync (
    .clk(sys_clk),
    .rst(rst),
    .en(clk_en),
    .d(sync_in),
    .q(sync_q)
  );

  // serial data on line one, clock pin is line zero
  assign serial_data_in = host_data_bus_in[1];

  // deselect clears the serial bit count
  hiss_shift u_shift (
    .ser_clk(ser_clk),
    .rst(rst),
    .cs_n(cs_n),
    .serial_data_in(serial_data_in),
    .dc_sel(dc_sel),
    .word(link_word),
    .tog(link_tog)
  );

  // pin reset joins the system reset
  assign core_rst = rst | ~rst_pin_n_q;
  assign ready = !core_rst && ld_cnt_ff == 3'h0;
  assign wr_now = wr_act(mode_ff, ctl_q);
  assign rd_now = rd_act(mode_ff, ctl_q);
  assign is_serial = mode_ff == hiss_pkg::MODE_SER3 ||
                     mode_ff == hiss_pkg::MODE_SER4;
  assign ser_new = tog_q != tog_seen_ff;

  // core init flag while reset is in force
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      init_ff <= 1'h1;
    end else if (clk_en) begin
      init_ff <= ~rst_pin_n_q;
    end
  end

  // strap capture window after each reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ld_cnt_ff <= hiss_pkg::STRAP_LD_CYCLES;
      mode_ff <= hiss_pkg::MODE_SER4;
    end else if (clk_en) begin
      if (!rst_pin_n_q) begin
        ld_cnt_ff <= hiss_pkg::STRAP_LD_CYCLES;
      end else if (ld_cnt_ff != 3'h0) begin
        ld_cnt_ff <= ld_cnt_ff - 3'h1;
      end
      if (ld_cnt_ff != 3'h0 || !rst_pin_n_q) begin
        mode_ff <= hiss_pkg::strap_to_mode(strap_q);
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      hiss_pkg::ST_IDLE: begin
        if (ready && wr_now) begin
          nxt_state = hiss_pkg::ST_WRITE;
        end else if (ready && rd_now) begin
          nxt_state = hiss_pkg::ST_READ;
        end
      end
      hiss_pkg::ST_WRITE: begin
        if (!wr_now) begin
          nxt_state = hiss_pkg::ST_IDLE;
        end
      end
      hiss_pkg::ST_READ: begin
        if (!rd_now) begin
          nxt_state = hiss_pkg::ST_IDLE;
        end
      end
      default: nxt_state = hiss_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      state_ff <= hiss_pkg::ST_IDLE;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // bus and selector follow the strobe; last value wins
  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      cap_ff <= '{is_data: 1'h0, value: 8'h00};
    end else if (clk_en && wr_now) begin
      cap_ff <= '{is_data: ctl_q.dc, value: bus_q};
    end
  end

  always_comb begin
    nxt_rx = cap_ff;
    nxt_go = 1'b0;
    if (state_ff == hiss_pkg::ST_WRITE && !wr_now) begin
      nxt_go = 1'b1;
    end else if (ser_new && is_serial && ready) begin
      nxt_go = 1'b1;
      nxt_rx = link_word;
      // selector is tied low in 3-wire mode
      if (mode_ff == hiss_pkg::MODE_SER3) begin
        nxt_rx.is_data = 1'b0;
      end
    end
  end

  // one write per byte, toggle seen once
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tog_seen_ff <= 1'h0;
      cmd_valid_ff <= 1'h0;
      data_valid_ff <= 1'h0;
      rx_ff <= 8'h00;
    end else if (clk_en) begin
      tog_seen_ff <= tog_q;
      cmd_valid_ff <= nxt_go && !nxt_rx.is_data;
      data_valid_ff <= nxt_go && nxt_rx.is_data;
      if (nxt_go) begin
        rx_ff <= nxt_rx.value;
      end
    end
  end

  // read: request once, drive bus while strobed
  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      rd_req_ff <= 1'h0;
      rd_is_data_ff <= 1'h0;
      bus_out_ff <= hiss_pkg::BUS_IDLE;
      bus_oe_n_ff <= 1'h1;
    end else if (clk_en) begin
      rd_req_ff <= state_ff == hiss_pkg::ST_IDLE &&
                   nxt_state == hiss_pkg::ST_READ;
      if (state_ff == hiss_pkg::ST_IDLE) begin
        rd_is_data_ff <= ctl_q.dc;
      end
      bus_oe_n_ff <= nxt_state != hiss_pkg::ST_READ;
      bus_out_ff <= state_ff == hiss_pkg::ST_READ ? rd_data
                                                  : hiss_pkg::BUS_IDLE;
    end
  end

  // aux pins: drive when direction is output
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aux_a_out_ff <= 1'h0;
      aux_a_oe_n_ff <= 1'h1;
      aux_b_out_ff <= 1'h0;
      aux_b_oe_n_ff <= 1'h1;
    end else if (clk_en) begin
      aux_a_out_ff <= aux_pin_a_val;
      aux_a_oe_n_ff <= ~aux_pin_a_dir;
      aux_b_out_ff <= aux_pin_b_val;
      aux_b_oe_n_ff <= ~aux_pin_b_dir;
    end
  end

  // outputs
  assign core_init = init_ff;
  assign mode = mode_ff;
  assign cmd_valid = cmd_valid_ff;
  assign data_valid = data_valid_ff;
  assign rx_byte = rx_ff;
  assign rd_req = rd_req_ff;
  assign rd_is_data = rd_is_data_ff;
  assign host_data_bus_out = bus_out_ff;
  assign host_data_bus_oe_n = bus_oe_n_ff;
  assign aux_pin_a_out = aux_a_out_ff;
  assign aux_pin_a_oe_n = aux_a_oe_n_ff;
  assign aux_pin_a_level = aux_q[1];
  assign aux_pin_b_out = aux_b_out_ff;
  assign aux_pin_b_oe_n = aux_b_oe_n_ff;
  assign aux_pin_b_level = aux_q[0];

  // checks
  property p_mode_caught;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && rst_pin_n_q && ld_cnt_ff == 3'h1) |=>
      mode_ff == hiss_pkg::strap_to_mode($past(strap_q));
  endproperty
  a_mode_caught: assert property (p_mode_caught)
    else $error("mode differs from strap code");

  property p_init_on_pin;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && !rst_pin_n_q) |=> init_ff && state_ff == hiss_pkg::ST_IDLE;
  endproperty
  a_init_on_pin: assert property (p_init_on_pin)
    else $error("pin reset did not reinitialise");

  property p_deselect_idle;
    @(posedge sys_clk) disable iff (rst)
    (state_ff == hiss_pkg::ST_IDLE && ctl_q.cs_n) |=>
      state_ff == hiss_pkg::ST_IDLE;
  endproperty
  a_deselect_idle: assert property (p_deselect_idle)
    else $error("transfer started while deselected");

  property p_par_data;
    @(posedge sys_clk) disable iff (core_rst)
    (clk_en && state_ff == hiss_pkg::ST_WRITE && !wr_now && cap_ff.is_data)
      |=> data_valid_ff && !cmd_valid_ff && rx_ff == $past(cap_ff.value);
  endproperty
  a_par_data: assert property (p_par_data)
    else $error("parallel data byte not sent to memory");

  property p_par_cmd;
    @(posedge sys_clk) disable iff (core_rst)
    (clk_en && state_ff == hiss_pkg::ST_WRITE && !wr_now && !cap_ff.is_data)
      |=> cmd_valid_ff && !data_valid_ff && rx_ff == $past(cap_ff.value);
  endproperty
  a_par_cmd: assert property (p_par_cmd)
    else $error("parallel command byte misrouted");

  property p_ser_route;
    @(posedge sys_clk) disable iff (core_rst)
    (clk_en && ready && ser_new && mode_ff == hiss_pkg::MODE_SER4) |=>
      (data_valid_ff == $past(link_word.is_data)) &&
      (cmd_valid_ff == !$past(link_word.is_data));
  endproperty
  a_ser_route: assert property (p_ser_route)
    else $error("serial byte misrouted");

  property p_strobe_read;
    @(posedge sys_clk) disable iff (core_rst)
    (clk_en && ready && state_ff == hiss_pkg::ST_IDLE && !wr_now &&
     mode_ff == hiss_pkg::MODE_PAR80 && !ctl_q.cs_n && !ctl_q.e_rd) |=>
      (state_ff == hiss_pkg::ST_READ && rd_req_ff && !bus_oe_n_ff)
      ##1 !rd_req_ff;
  endproperty
  a_strobe_read: assert property (p_strobe_read)
    else $error("read strobe not honoured");

  property p_enable_write;
    @(posedge sys_clk) disable iff (core_rst)
    (clk_en && ready && state_ff == hiss_pkg::ST_IDLE &&
     mode_ff == hiss_pkg::MODE_PAR68 && !ctl_q.cs_n && ctl_q.e_rd &&
     !ctl_q.rw_wr) |=> state_ff == hiss_pkg::ST_WRITE && !rd_req_ff;
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable write not honoured");

  property p_one_pulse;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && (cmd_valid_ff || data_valid_ff)) |=>
      !(cmd_valid_ff || data_valid_ff);
  endproperty
  a_one_pulse: assert property (p_one_pulse)
    else $error("byte written more than once");

  property p_aux_dir;
    @(posedge sys_clk) disable iff (rst)
    clk_en |=> aux_a_oe_n_ff == !$past(aux_pin_a_dir) &&
               aux_b_oe_n_ff == !$past(aux_pin_b_dir);
  endproperty
  a_aux_dir: assert property (p_aux_dir)
    else $error("aux pin direction not followed");

  property p_serial_quiet;
    @(posedge sys_clk) disable iff (rst)
    is_serial |-> bus_oe_n_ff [*2];
  endproperty
  a_serial_quiet: assert property (p_serial_quiet)
    else $error("bus driven in serial mode");

  c_par_write: cover property (@(posedge sys_clk) disable iff (rst)
    state_ff == hiss_pkg::ST_WRITE ##[1:20] data_valid_ff);
  c_par_read: cover property (@(posedge sys_clk) disable iff (rst)
    rd_req_ff ##1 !bus_oe_n_ff);
  c_ser_byte: cover property (@(posedge sys_clk) disable iff (rst)
    is_serial && cmd_valid_ff);

endmodule : hiss_host_port
`default_nettype wire

// ===== hiss_host_model.sv
// host controller model: control pins, data bus and serial clock
// assumes the bench resolves the bus and feeds its level back
`timescale 1ns/1ps
`default_nettype none
module hiss_host_model (
  // clock and strap code
  input wire logic sys_clk,
  input wire logic [1:0] strap,
  // host pins
  output logic cs_n,
  output logic dc_sel,
  output logic rw_wr,
  output logic e_rd,
  output logic ser_clk,
  output logic [7:0] bus_drv,
  output logic bus_en,
  input wire logic [7:0] bus_lvl
);
  // pins at rest, serial clock parked low
  initial begin
    cs_n = 1'b1;
    dc_sel = 1'b0;
    rw_wr = 1'b0;
    e_rd = 1'b0;
    ser_clk = 1'b0;
    bus_drv = 8'h00;
    bus_en = 1'b1;
  end

  task automatic idle();
    cs_n <= 1'b1;
    dc_sel <= 1'b0;
    rw_wr <= strap[1];
    e_rd <= (strap == hiss_pkg::STRAP_PAR80);
    bus_drv <= 8'h00;
    bus_en <= 1'b1;
  endtask : idle

  task automatic par_xfer(input logic sel_n, input logic dc,
                          input logic is_rd, input logic [7:0] b,
                          output logic [7:0] got);
    @(posedge sys_clk);
    cs_n <= sel_n;
    dc_sel <= dc;
    bus_drv <= b;
    bus_en <= !is_rd;
    if (strap == hiss_pkg::STRAP_PAR68) begin
      rw_wr <= is_rd;
      e_rd <= 1'b1;
    end else if (is_rd) begin
      e_rd <= 1'b0;
    end else begin
      rw_wr <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
    got = bus_lvl;
    idle();
    repeat (10) @(posedge sys_clk);
  endtask : par_xfer

  // selector tied low in 3-wire mode
  // msb first on line one, clock on line zero
  task automatic ser_byte(input logic sel_n, input logic dc,
                          input logic [7:0] b);
    @(posedge sys_clk);
    cs_n <= sel_n;
    dc_sel <= (strap == hiss_pkg::STRAP_SER3) ? 1'b0 : dc;
    #7;
    for (int i = 7; i >= 0; i--) begin
      bus_drv[1] = b[i];
      #6;
      ser_clk = 1'b1;
      bus_drv[0] = 1'b1;
      #6;
      ser_clk = 1'b0;
      bus_drv[0] = 1'b0;
    end
    @(posedge sys_clk);
    idle();
    repeat (10) @(posedge sys_clk);
  endtask : ser_byte
endmodule : hiss_host_model
`default_nettype wire

// ===== host_interface_select_steer_tb.sv
// bench for the host port: all straps, writes, reads, refused bytes,
// reset pin and aux pins; a monitor checks each byte against notes
// assumes the design files and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module host_interface_select_steer_tb;
  logic sys_clk, rst, proto_sel_lo, proto_sel_hi, reset_n_in;
  logic [7:0] rd_data, bus_lvl, bus_out, h_drv, rx_byte;
  logic a_dir, a_val, a_in, b_dir, b_val, b_in;
  logic cs_n, dc_sel, rw_wr, e_rd, ser_clk, h_en, bus_oe_n;
  logic core_init, cmd_valid, data_valid, rd_req, rd_is_data;
  logic a_out, a_oe_n, a_lvl, b_out, b_oe_n, b_lvl;
  logic [1:0] strap;
  hiss_pkg::hiss_mode_t mode;
  hiss_pkg::hiss_mode_t modes [4];
  hiss_pkg::hiss_byte_t notes[$];
  hiss_pkg::hiss_byte_t note;
  int seed, bad_count, n_compared, n_reads, n_rd_exp;
  logic rd_dc_exp;
  logic [9:0] got_v, exp_v;

  // strap code and resolved bus, undriven bus shows the inverse
  assign strap = {proto_sel_hi, proto_sel_lo};
  assign bus_lvl = !bus_oe_n ? bus_out : (h_en ? h_drv : ~h_drv);

  hiss_host_model host (.sys_clk(sys_clk), .strap(strap), .cs_n(cs_n),
    .dc_sel(dc_sel), .rw_wr(rw_wr), .e_rd(e_rd), .ser_clk(ser_clk),
    .bus_drv(h_drv), .bus_en(h_en), .bus_lvl(bus_lvl));

  hiss_host_port dut (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
    .ser_clk(ser_clk), .proto_sel_lo(proto_sel_lo),
    .proto_sel_hi(proto_sel_hi), .reset_n_in(reset_n_in), .cs_n(cs_n),
    .dc_sel(dc_sel), .rw_wr(rw_wr), .e_rd(e_rd),
    .host_data_bus_in(bus_lvl), .host_data_bus_out(bus_out),
    .host_data_bus_oe_n(bus_oe_n), .rd_data(rd_data),
    .core_init(core_init), .mode(mode), .cmd_valid(cmd_valid),
    .data_valid(data_valid), .rx_byte(rx_byte), .rd_req(rd_req),
    .rd_is_data(rd_is_data), .aux_pin_a_dir(a_dir),
    .aux_pin_a_val(a_val), .aux_pin_a_in(a_in), .aux_pin_a_out(a_out),
    .aux_pin_a_oe_n(a_oe_n), .aux_pin_a_level(a_lvl),
    .aux_pin_b_dir(b_dir), .aux_pin_b_val(b_val), .aux_pin_b_in(b_in),
    .aux_pin_b_out(b_out), .aux_pin_b_oe_n(b_oe_n),
    .aux_pin_b_level(b_lvl));

  // system clock, 25 ns
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // monitor: every pulse takes the oldest note, extra pulses fail
  always @(posedge sys_clk) begin
    if (!rst && rd_req === 1'b1) begin
      n_reads++;
      `CHK(rd_is_data, rd_dc_exp)
    end
    if (!rst && (cmd_valid !== 1'b0 || data_valid !== 1'b0)) begin
      note = notes.size() ? notes.pop_front() : 9'bx_xxxx_xxxx;
      got_v = {data_valid, cmd_valid, rx_byte};
      exp_v = {note.is_data, !note.is_data, note.value};
      `CHK(got_v, exp_v)
    end
  end

  task automatic close_out();
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic restart(input logic [1:0] code);
    @(posedge sys_clk);
    rst <= 1'b1;
    proto_sel_hi <= code[1];
    proto_sel_lo <= code[0];
    @(posedge sys_clk);
    host.idle();
    repeat (7) @(posedge sys_clk);
    `CHK(core_init, 1'b1)
    rst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    `CHK(mode, modes[code])
    `CHK(core_init, 1'b0)
  endtask : restart

  // one byte, noted only when selected
  task automatic wr(input logic sel_n, input logic dc);
    logic [7:0] b;
    logic [7:0] got;
    b = 8'($random(seed));
    if (!sel_n) begin
      notes.push_back({dc & (strap != hiss_pkg::STRAP_SER3), b});
    end
    if (strap[1]) host.par_xfer(sel_n, dc, 1'b0, b, got);
    else host.ser_byte(sel_n, dc, b);
  endtask : wr

  // read returns core data, bus released after
  task automatic rd(input logic dc);
    logic [7:0] got;
    rd_data <= 8'($random(seed));
    rd_dc_exp = dc;
    n_rd_exp++;
    host.par_xfer(1'b0, dc, 1'b1, 8'h00, got);
    `CHK(got, rd_data)
    `CHK(bus_oe_n, 1'b1)
  endtask : rd

  // aux pins as outputs and inputs
  task automatic aux_check();
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      {a_dir, a_val, a_in, b_dir, b_val, b_in} <= 6'($random(seed));
      repeat (6) @(posedge sys_clk);
      `CHK({a_out, a_oe_n, a_lvl}, {a_val, !a_dir, a_in})
      `CHK({b_out, b_oe_n, b_lvl}, {b_val, !b_dir, b_in})
    end
  endtask : aux_check

  // main sequence over all four straps
  initial begin
    seed = 41;
    bad_count = 0;
    n_compared = 0;
    n_reads = 0;
    n_rd_exp = 0;
    modes = '{hiss_pkg::MODE_SER4, hiss_pkg::MODE_SER3,
              hiss_pkg::MODE_PAR80, hiss_pkg::MODE_PAR68};
    rst = 1'b1;
    proto_sel_lo = 1'b0;
    proto_sel_hi = 1'b0;
    reset_n_in = 1'b1;
    rd_data = 8'h00;
    {a_dir, a_val, a_in, b_dir, b_val, b_in} = 6'h00;
    for (int c = 0; c < 4; c++) begin
      restart(2'(c));
      wr(1'b0, 1'b0);
      wr(1'b0, 1'b1);
      wr(1'b1, 1'b1);
      wr(1'b0, 1'b0);
      if (strap[1]) begin
        rd(1'b0);
        rd(1'b1);
      end
      aux_check();
    end
    // reset pin pulsed low then held high
    @(posedge sys_clk);
    reset_n_in <= 1'b0;
    repeat (8) @(posedge sys_clk);
    `CHK(core_init, 1'b1)
    reset_n_in <= 1'b1;
    repeat (12) @(posedge sys_clk);
    `CHK(core_init, 1'b0)
    wr(1'b0, 1'b1);
    repeat (20) @(posedge sys_clk);
    `CHK(notes.size(), 0)
    `CHK(n_reads, n_rd_exp)
    close_out();
  end

  // watchdog, about eight times the expected run
  initial begin
    #125000;
    bad_count++;
    close_out();
  end
endmodule : host_interface_select_steer_tb
`default_nettype wire
